// [hw/timer0_map.vh]
// Purpose: register map and constants of the 8-bit timer
// Assumes: AHB-Lite word registers, 32-bit data
// Notes:   definitions only
`ifndef TIMER0_MAP_VH
`define TIMER0_MAP_VH

// ------------------------------
// Register offsets (byte addr)
// ------------------------------
`define OFS_CONTROL  8'h00
`define OFS_COUNTER  8'h04
`define OFS_COMPARE  8'h08
`define OFS_FLAGS    8'h0c
`define OFS_MASK     8'h10
`define OFS_ASYNC    8'h14

// ------------------------------
// Field positions
// ------------------------------
`define CTL_WGM_LO   0
`define CTL_WGM_HI   1
`define CTL_COM_LO   2
`define CTL_COM_HI   3
`define CTL_CS_LO    4
`define CTL_CS_HI    6
`define CTL_FORCE    7
`define FLG_OVF      0
`define FLG_CMP      1

// ------------------------------
// Values
// ------------------------------
`define CNT_BOTTOM   8'h00
`define CNT_MAX      8'hff
`define WGM_NORMAL   2'h0
`define WGM_PCPWM    2'h1
`define WGM_CTC      2'h2
`define WGM_FASTPWM  2'h3
`define COM_NONE     2'h0
`define COM_TOGGLE   2'h1
`define COM_CLEAR    2'h2
`define COM_SET      2'h3
`define CS_STOP      3'h0
`define RST_BYTE     8'h00
`define PRE_W        10

`endif

// [hw/timer0_counter_compare.v]
// Purpose: 8-bit timer/counter, one compare channel, AHB-Lite regs
// Assumes: hclk is the I/O clock; osc_pin_in is asynchronous
// Notes:   zero-wait-state slave, response always OKAY
//
// Behaviour
// R01: Counter and compare registers are 8 bits, readable and writable.
// R02: Tick from I/O clock, or from crystal pin when async selected.
// R03: Clock select zero stops the counter completely.
// R04: Counter readable and writable with or without a tick.
// R05: Processor write to counter beats a same-cycle clear or count.
// R06: Each tick clears, increments or decrements per waveform mode.
// R07: Bottom at 0x00, max at 0xFF.
// R08: Top is 0xFF or the compare register, per mode.
// R09: Two waveform select bits choose the count sequence.
// R10: Comparator signals match whenever counter equals compare.
// R11: Match sets the compare flag at the next tick.
// R12: Enabled flag requests interrupt; cleared by service or writing one.
// R13: PWM modes double-buffer compare, update at top or bottom.
// R14: Buffered accesses reach the buffer, else the active register.
// R15: Force strobe acts like a match on output only, non-PWM.
// R16: Counter write blocks a match in the following tick.
// R17: Output compare state survives waveform mode changes.
// R18: Compare output action bits take effect immediately.
// R19: Overflow flag set per mode and can raise an interrupt.
// R20: Waveform unit uses match, mode, action, max and bottom.
// R21: Software presets output state before enabling the pin.
// R22: Software avoids writes whose match would be lost.
// R23: Normal mode counts up, wraps, overflow at zero.
// R24: Clear-on-match mode clears counter on compare match.
// R25: Fast PWM counts bottom to max; non-inverting clears/sets.
// R26: Action zero leaves the output state unchanged on match.
// R27: Mode 1 is phase-correct PWM, up to max then down.
`timescale 1ns/100ps
`include "timer0_map.vh"

module timer0_counter_compare
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        osc_pin_in,
   output reg         osc_pin_out,
   input  wire        overflow_irq_ack,
   input  wire        compare_irq_ack,
   output wire        overflow_irq,
   output wire        compare_irq,
   output reg         compare_output,
   output wire        compare_output_en
);

// ------------------------------
// Register state
// ------------------------------
reg  [1:0]  waveform_select;
reg  [1:0]  compare_output_action;
reg  [2:0]  clock_select;
reg         async_clock_select;
reg  [7:0]  counter_value;                                     // R01
reg  [7:0]  compare_value;
reg  [7:0]  compare_buffer;
reg         overflow_flag;
reg         compare_match_flag;
reg         overflow_irq_enable;
reg         compare_irq_enable;
reg         count_down;
reg         block_match;

// ------------------------------
// AHB-Lite slave
// ------------------------------
reg         wr_pend;
reg  [7:0]  wr_addr;
wire        addr_phase = hsel & hready & htrans[1];
wire        wr_stb     = wr_pend;
wire [7:0]  wd         = hwdata[7:0];
wire        pwm_mode   = waveform_select[0];

assign hreadyout = 1'b1;
assign hresp     = 1'b0;

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      wr_pend <= 1'b0;
      wr_addr <= `RST_BYTE;
   end
   else
   begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr;
   end
end

wire w_ctl = wr_stb & (wr_addr == `OFS_CONTROL);
wire w_cnt = wr_stb & (wr_addr == `OFS_COUNTER);
wire w_cmp = wr_stb & (wr_addr == `OFS_COMPARE);
wire w_flg = wr_stb & (wr_addr == `OFS_FLAGS);
wire w_msk = wr_stb & (wr_addr == `OFS_MASK);
wire w_asy = wr_stb & (wr_addr == `OFS_ASYNC);

// Read data is latched at the address phase, so it stands in the
// data phase with no wait state.
reg [7:0] rd_byte;
always @*
begin
   rd_byte = `RST_BYTE;
   case (haddr)
      `OFS_CONTROL: rd_byte = {1'b0, clock_select, compare_output_action, waveform_select};
      `OFS_COUNTER: rd_byte = counter_value;                                      // R04
      `OFS_COMPARE: rd_byte = pwm_mode ? compare_buffer : compare_value;          // R14
      `OFS_FLAGS:   rd_byte = {6'h00, compare_match_flag, overflow_flag};
      `OFS_MASK:    rd_byte = {6'h00, compare_irq_enable, overflow_irq_enable};
      `OFS_ASYNC:   rd_byte = {7'h00, async_clock_select};
      default:      rd_byte = `RST_BYTE;
   endcase
end

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
      hrdata <= 32'h00000000;
   else if (addr_phase & ~hwrite)
      hrdata <= {24'h000000, rd_byte};
end

// ------------------------------
// Clock source and prescaler
// ------------------------------
reg         osc_s1;
reg         osc_s2;
reg         osc_s3;
reg  [`PRE_W-1:0] prescale;
reg         tap;

// Crystal pin passes two flops; edge found after the second
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      osc_s1      <= 1'b0;
      osc_s2      <= 1'b0;
      osc_s3      <= 1'b0;
      osc_pin_out <= 1'b0;
   end
   else
   begin
      osc_s1      <= osc_pin_in;
      osc_s2      <= osc_s1;
      osc_s3      <= osc_s2;
      osc_pin_out <= ~osc_s2;
   end
end

wire src_tick = async_clock_select ? (osc_s2 & ~osc_s3) : 1'b1;   // R02

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
      prescale <= {`PRE_W{1'b0}};
   else if (src_tick)
      prescale <= prescale + 1'b1;
end

// A tap fires when its low prescaler bits roll over to zero
wire [`PRE_W-1:0] pre_next = prescale + 1'b1;
always @*
begin
   tap = 1'b0;
   case (clock_select)
      `CS_STOP: tap = 1'b0;                                    // R03
      3'h1:     tap = 1'b1;
      3'h2:     tap = (pre_next[2:0] == 3'h0);
      3'h3:     tap = (pre_next[4:0] == 5'h00);
      3'h4:     tap = (pre_next[5:0] == 6'h00);
      3'h5:     tap = (pre_next[6:0] == 7'h00);
      3'h6:     tap = (pre_next[7:0] == 8'h00);
      3'h7:     tap = (pre_next == {`PRE_W{1'b0}});
      default:  tap = 1'b0;
   endcase
end

wire timer_tick = src_tick & tap;                              // R02

// ------------------------------
// Comparator and extremes
// ------------------------------
wire at_bottom = (counter_value == `CNT_BOTTOM);               // R07
wire at_max    = (counter_value == `CNT_MAX);                  // R07
wire match     = (counter_value == compare_value);             // R10
wire tick_match = timer_tick & match & ~block_match;           // R16
wire [7:0] top_value = (waveform_select == `WGM_CTC)
                       ? compare_value : `CNT_MAX;             // R08
wire at_top    = (counter_value == top_value);

// ------------------------------
// Counter unit
// ------------------------------
reg [7:0] next_counter;
reg       next_down;
always @*
begin
   next_counter = counter_value;
   next_down    = count_down;
   case (waveform_select)                                      // R09
      `WGM_NORMAL, `WGM_FASTPWM:
         next_counter = counter_value + 8'h01;                 // R23 R25
      `WGM_CTC:
         next_counter = tick_match ? `CNT_BOTTOM : counter_value + 8'h01; // R24
      `WGM_PCPWM:
      begin
         if (at_max)
            next_down = 1'b1;                                  // R27
         else if (at_bottom)
            next_down = 1'b0;
         if (next_down)
            next_counter = counter_value - 8'h01;
         else
            next_counter = counter_value + 8'h01;
      end
      default:
         next_counter = counter_value;
   endcase
end

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      counter_value <= `RST_BYTE;
      count_down    <= 1'b0;
   end
   else if (w_cnt)
      counter_value <= wd;                                     // R05
   else if (timer_tick)
   begin
      counter_value <= next_counter;                           // R06
      count_down    <= next_down;
   end
end

// A counter write blocks the match of the next tick, even when stopped
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
      block_match <= 1'b0;
   else if (w_cnt)
      block_match <= 1'b1;                                     // R16
   else if (timer_tick)
      block_match <= 1'b0;
end

// ------------------------------
// Compare register and buffer
// ------------------------------
wire buf_update = timer_tick & pwm_mode & at_top;              // R13

always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      compare_value  <= `RST_BYTE;
      compare_buffer <= `RST_BYTE;
   end
   else
   begin
      if (w_cmp)
         compare_buffer <= wd;                                 // R14
      if (w_cmp & ~pwm_mode)
         compare_value <= wd;                                  // R13
      else if (buf_update)
         compare_value <= compare_buffer;                      // R13
   end
end

// ------------------------------
// Control registers
// ------------------------------
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      waveform_select       <= `WGM_NORMAL;
      compare_output_action <= `COM_NONE;
      clock_select          <= `CS_STOP;
      overflow_irq_enable   <= 1'b0;
      compare_irq_enable    <= 1'b0;
      async_clock_select    <= 1'b0;
   end
   else
   begin
      if (w_ctl)
      begin
         waveform_select       <= wd[`CTL_WGM_HI:`CTL_WGM_LO];
         compare_output_action <= wd[`CTL_COM_HI:`CTL_COM_LO]; // R18
         clock_select          <= wd[`CTL_CS_HI:`CTL_CS_LO];
      end
      if (w_msk)
      begin
         overflow_irq_enable <= wd[`FLG_OVF];
         compare_irq_enable  <= wd[`FLG_CMP];
      end
      if (w_asy)
         async_clock_select <= wd[0];
   end
end

// ------------------------------
// Flags and interrupt requests
// ------------------------------
// Phase-correct PWM overflows at the bottom turn; the others on the wrap
wire ovf_event = (waveform_select == `WGM_PCPWM) ? (at_bottom & count_down)
                                                 : at_max;     // R23

wire set_ovf = timer_tick & ovf_event;                         // R19
wire clr_ovf = (w_flg & wd[`FLG_OVF]) | overflow_irq_ack;
wire clr_cmp = (w_flg & wd[`FLG_CMP]) | compare_irq_ack;

// Set wins over a clear in the same cycle
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
   begin
      overflow_flag      <= 1'b0;
      compare_match_flag <= 1'b0;
   end
   else
   begin
      if (set_ovf)
         overflow_flag <= 1'b1;                                // R19
      else if (clr_ovf)
         overflow_flag <= 1'b0;
      if (tick_match)
         compare_match_flag <= 1'b1;                           // R11
      else if (clr_cmp)
         compare_match_flag <= 1'b0;                           // R12
   end
end

assign overflow_irq = overflow_flag & overflow_irq_enable;     // R19
assign compare_irq  = compare_match_flag & compare_irq_enable; // R12

// ------------------------------
// Waveform generator
// ------------------------------
// A force takes the action and mode bits of the very write that carries it
wire       force_hit = w_ctl & wd[`CTL_FORCE] & ~wd[`CTL_WGM_LO];    // R15
wire [1:0] act_now   = force_hit ? wd[`CTL_COM_HI:`CTL_COM_LO]
                                 : compare_output_action;            // R18
reg        next_out;
always @*
begin
   next_out = compare_output;
   if (force_hit | (~pwm_mode & tick_match))                         // R20
   begin
      case (act_now)
         `COM_TOGGLE: next_out = ~compare_output;
         `COM_CLEAR:  next_out = 1'b0;
         `COM_SET:    next_out = 1'b1;
         default:     next_out = compare_output;                     // R26
      endcase
   end
   else if (pwm_mode & compare_output_action[1])
   begin
      if (waveform_select == `WGM_FASTPWM)
      begin
         // Wrap to bottom sets, match clears (non-inverting)
         if (timer_tick & at_max)
            next_out = ~compare_output_action[0];              // R25
         else if (tick_match)
            next_out = compare_output_action[0];               // R25
      end
      else if (tick_match)
         next_out = compare_output_action[0] ^ count_down;     // R20
   end
end

// Never reset by a mode change, only by the hardware reset
always @(posedge hclk or negedge hresetn)
begin
   if (!hresetn)
      compare_output <= 1'b0;
   else
      compare_output <= next_out;                              // R17
end

// Pin override whenever any action bit is set; R21 is up to software
assign compare_output_en = |compare_output_action;             // R18

endmodule // timer0_counter_compare

// [test/timer0_counter_compare_monitor.sv]
// Purpose: port checker for the 8-bit timer
// Assumes: control at 0x00, mask at 0x10, zero-wait-state slave
// Notes:   bound from the testbench top file
`timescale 1ns/100ps
`include "timer0_map.vh"

module timer0_monitor
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        overflow_irq,
   input wire logic        compare_irq,
   input wire logic        compare_output,
   input wire logic        compare_output_en
);
   logic       dp_ctl;
   logic       dp_msk;
   logic [1:0] act_q;
   logic [1:0] mask_q;
   wire        wr_ok = hsel && hready && htrans[1] && hwrite;

   // --------------------------------------
   // Shadow of action and mask bits
   // --------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_ctl <= 1'b0;
         dp_msk <= 1'b0;
         act_q  <= 2'h0;
         mask_q <= 2'h0;
      end
      else
      begin
         dp_ctl <= wr_ok && (haddr == `OFS_CONTROL);
         dp_msk <= wr_ok && (haddr == `OFS_MASK);
         if (dp_ctl)
            act_q <= hwdata[3:2];
         if (dp_msk)
            mask_q <= hwdata[1:0];
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_rdata_hi; hrdata[31:8] == 24'h0; endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("slave stalled or erred");
   property p_oe_follow; compare_output_en == (act_q != 2'h0); endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("pin override lags action");
   property p_cmp_mask; !mask_q[1] |-> !compare_irq; endproperty
   a_cmp_mask: assert property (p_cmp_mask) else $error("masked compare irq");
   property p_ovf_mask; !mask_q[0] |-> !overflow_irq; endproperty
   a_ovf_mask: assert property (p_ovf_mask) else $error("masked overflow irq");
   property p_force_set;
      dp_ctl && hwdata[7] && !hwdata[0] && hwdata[3:2] == 2'h3 |=> ##[0:1] compare_output;
   endproperty
   a_force_set: assert property (p_force_set) else $error("forced set missing");
   property p_force_clr;
      dp_ctl && hwdata[7] && !hwdata[0] && hwdata[3:2] == 2'h2 |=> ##[0:1] !compare_output;
   endproperty
   a_force_clr: assert property (p_force_clr) else $error("forced clear missing");
   property p_act_none; act_q == 2'h0 && !dp_ctl |=> $stable(compare_output); endproperty
   a_act_none: assert property (p_act_none) else $error("output moved with no action");
endmodule // timer0_monitor

// [test/testbench.sv]
// Purpose: self-checking bench of the 8-bit timer
// Assumes: single AHB-Lite master, one idle cycle between transfers
// Notes:   timing-loose checks use windows, never exact tick counts
`timescale 1ns/100ps

module testbench;
   reg         hclk;
   reg         hresetn;
   reg         hsel;
   reg  [7:0]  haddr;
   reg  [1:0]  htrans;
   reg         hwrite;
   reg  [31:0] hwdata;
   reg         osc_pin_in;
   reg         overflow_irq_ack;
   reg         compare_irq_ack;
   wire        hready;
   wire        hresp;
   wire [31:0] hrdata;
   wire        osc_pin_out;
   wire        overflow_irq;
   wire        compare_irq;
   wire        compare_output;
   wire        compare_output_en;
   integer     failures;
   integer     cmp_count;
   integer     i;
   integer     n;
   reg  [31:0] d;
   reg  [31:0] e;
   reg  [31:0] rnd;
   reg         mo;
   reg  [1:0]  acts [0:4];

   timer0_counter_compare timer0_counter_compare_i
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
      .overflow_irq_ack(overflow_irq_ack), .compare_irq_ack(compare_irq_ack),
      .overflow_irq(overflow_irq), .compare_irq(compare_irq), .compare_output(compare_output),
      .compare_output_en(compare_output_en)
   );

   initial hclk = 1'b0;
   always #50 hclk = ~hclk;

   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task chk(input [31:0] got, input [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   // --------------------------------------
   // Bus transfers, held until hready
   // --------------------------------------
   task xfer(input w, input [7:0] a, input [31:0] v);
   begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   end
   endtask

   task end_of_test;
   begin
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask

   initial
   begin
      #(30000 * 100);
      failures = failures + 1;
      end_of_test;
   end

   initial
   begin
      failures = 0; cmp_count = 0; rnd = 32'h71770e4d; mo = 1'b0;
      hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
      osc_pin_in = 1'b0; overflow_irq_ack = 1'b0; compare_irq_ack = 1'b0;
      acts[0] = 2'h3; acts[1] = 2'h1; acts[2] = 2'h1; acts[3] = 2'h2; acts[4] = 2'h3;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 7; i = i + 1)
      begin
         xfer(0, i * 4, 0);
         chk(d, 32'h0);
      end
      // Stopped timer keeps what was written; unmapped place stays zero
      for (i = 0; i < 4; i = i + 1)
      begin
         rnd = lfsr(rnd);
         xfer(1, 8'h04, rnd);
         xfer(1, 8'h08, rnd >> 8);
         xfer(1, 8'h18, rnd);
         repeat (9) @(posedge hclk);
         xfer(0, 8'h04, 0);
         chk(d, rnd[7:0]);
         xfer(0, 8'h08, 0);
         chk(d, rnd[15:8]);
         xfer(0, 8'h18, 0);
         chk(d, 32'h0);
      end
      // Forced compare in normal mode, clock stopped
      for (i = 0; i < 5; i = i + 1)
      begin
         xfer(1, 8'h00, 8'h80 | (acts[i] << 2));
         mo = (acts[i] == 2'h3) ? 1'b1 : (acts[i] == 2'h2) ? 1'b0 : !mo;
         repeat (2) @(posedge hclk);
         chk(compare_output, mo);
         chk(compare_output_en, 1'b1);
      end
      xfer(0, 8'h0c, 0);
      chk(d, 32'h0);
      xfer(1, 8'h00, 8'h03);
      repeat (2) @(posedge hclk);
      chk(compare_output, 1'b1);
      chk(compare_output_en, 1'b0);
      // Match after a counter write is lost, next one after wrap is kept
      xfer(1, 8'h00, 8'h00);
      xfer(1, 8'h08, 8'h10);
      xfer(1, 8'h04, 8'h10);
      xfer(1, 8'h0c, 8'h03);
      xfer(1, 8'h00, 8'h10);
      xfer(0, 8'h0c, 0);
      chk(d, 32'h0);
      repeat (300) @(posedge hclk);
      xfer(0, 8'h0c, 0);
      chk(d, 32'h3);
      xfer(1, 8'h00, 8'h00);
      xfer(0, 8'h04, 0);
      chk(d > 32'h30 && d < 32'h60, 1'b1);
      xfer(1, 8'h10, 8'h03);
      @(posedge hclk);
      chk({overflow_irq, compare_irq}, 2'h3);
      compare_irq_ack <= 1'b1;
      @(posedge hclk);
      compare_irq_ack <= 1'b0;
      xfer(1, 8'h0c, 8'h01);
      @(posedge hclk);
      chk({overflow_irq, compare_irq}, 2'h0);
      xfer(1, 8'h10, 8'h00);
      // Clear on match keeps the count at or below the compare value
      xfer(1, 8'h08, 8'h05);
      xfer(1, 8'h04, 8'h00);
      xfer(1, 8'h00, 8'h12);
      repeat (40) @(posedge hclk);
      xfer(1, 8'h00, 8'h02);
      xfer(0, 8'h04, 0);
      chk(d <= 32'h5, 1'b1);
      xfer(0, 8'h0c, 0);
      chk(d, 32'h2);
      // Fast PWM, compare reaches the buffer, duty follows it
      xfer(1, 8'h00, 8'h03);
      xfer(1, 8'h08, 8'h40);
      xfer(0, 8'h08, 0);
      chk(d, 32'h40);
      xfer(1, 8'h00, 8'h1b);
      repeat (300) @(posedge hclk);
      n = 0;
      repeat (256)
      begin
         @(posedge hclk);
         n = n + compare_output;
      end
      chk(n >= 8'h3f && n <= 8'h42, 1'b1);
      // Phase-correct PWM turns round at the top
      xfer(1, 8'h00, 8'h01);
      xfer(1, 8'h04, 8'h80);
      xfer(1, 8'h00, 8'h11);
      xfer(0, 8'h04, 0);
      e = d;
      xfer(0, 8'h04, 0);
      chk(d > e, 1'b1);
      repeat (150) @(posedge hclk);
      xfer(0, 8'h04, 0);
      e = d;
      xfer(0, 8'h04, 0);
      chk(d < e, 1'b1);
      // Crystal pin as tick source, one tick per rising edge
      xfer(1, 8'h00, 8'h00);
      xfer(1, 8'h14, 8'h01);
      xfer(1, 8'h04, 8'h00);
      xfer(1, 8'h00, 8'h10);
      repeat (10)
      begin
         repeat (4) @(posedge hclk);
         osc_pin_in <= 1'b1;
         repeat (4) @(posedge hclk);
         osc_pin_in <= 1'b0;
      end
      repeat (4) @(posedge hclk);
      chk(osc_pin_out, 1'b1);
      xfer(1, 8'h00, 8'h00);
      xfer(0, 8'h04, 0);
      chk(d, 32'ha);
      end_of_test;
   end
endmodule // testbench

bind timer0_counter_compare timer0_monitor timer0_monitor_i
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .overflow_irq(overflow_irq), .compare_irq(compare_irq), .compare_output(compare_output),
   .compare_output_en(compare_output_en)
);
